// ---- hdl/tlo_defs.vh ----
// Register offsets, reset values, field positions and codes of the thermal limit block
`ifndef TLO_DEFS_VH
`define TLO_DEFS_VH

// Register offsets (byte addresses on the plain register port)
`define TLO_ADDR_R1_START 8'h67
`define TLO_ADDR_LC_START 8'h68
`define TLO_ADDR_R2_START 8'h69
`define TLO_ADDR_R1_CRIT 8'h6A
`define TLO_ADDR_LC_CRIT 8'h6B
`define TLO_ADDR_R2_CRIT 8'h6C
`define TLO_ADDR_R1LC_HYST 8'h6D
`define TLO_ADDR_R2_HYST 8'h6E
`define TLO_ADDR_TEST_EN 8'h6F
`define TLO_ADDR_R1_OFFS 8'h70
`define TLO_ADDR_LC_OFFS 8'h71
`define TLO_ADDR_R2_OFFS 8'h72
`define TLO_ADDR_CTRL 8'hE0
`define TLO_ADDR_STATUS 8'hE1
`define TLO_ADDR_MASK 8'hE2

// Power-on values
`define TLO_RST_START 8'h5A
`define TLO_RST_CRIT 8'h64
`define TLO_RST_R1LC_HYST 8'h44
`define TLO_RST_R2_HYST 8'h40
`define TLO_RST_ZERO 8'h00

// Critical limit value that turns the full-speed override off
`define TLO_CRIT_DISABLE 8'h80
// Full-scale duty
`define TLO_DUTY_FULL 8'hFF

// Field positions
`define TLO_TEST_EN_BIT 0
`define TLO_CTRL_PIN_OUT_BIT 0
`define TLO_HYST_HI_MSB 7
`define TLO_HYST_HI_LSB 4
`define TLO_HYST_LO_MSB 3
`define TLO_HYST_LO_LSB 0

// Channel indices
`define TLO_CH_R1 0
`define TLO_CH_LC 1
`define TLO_CH_R2 2

// Status bit positions: per-channel critical entry and fan-start entry
`define TLO_ST_CRIT_LSB 0
`define TLO_ST_START_LSB 3
`define TLO_ST_WIDTH 6

// Fan state codes
`define TLO_FAN_OFF 2'h0
`define TLO_FAN_RUN 2'h1
`define TLO_FAN_FLOOR 2'h2

// Fraction bits of a reading (quarter degree steps)
`define TLO_FRAC_BITS 2
// Overtemp pin trips one quarter step above critical entry, two quarter steps above the limit
`define TLO_PIN_MARGIN 12'h001

`endif

// ---- hdl/tlo_thermal_limit_offset_regs.v ----
// Thermal thresholds, offsets, fan overrides and overtemp pin for three channels
`timescale 1ns/1ps
`include "tlo_defs.vh"

module tlo_thermal_limit_offset_regs #(
    parameter TEMP_W = 10 // Reading width: 8 integer bits, 2 quarter bits, signed
) (
    input wire clk, // 40 MHz core clock
    input wire rstn, // Asynchronous reset, active low
    input wire [7:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Register write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    output reg [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    input wire lock, // Global lock level from the configuration block
    input wire [3*TEMP_W-1:0] raw_temp, // Raw readings lc,signed quarter degrees
    input wire temp_valid, // Readings updated this cycle
    input wire [3*8-1:0] ramp_duty, // Ramp duty per fan from the duty calculator
    input wire [3*8-1:0] floor_duty, // Floor duty per fan
    input wire overtemp_pin_in, // Overtemp pin level from outside
    output reg [3*TEMP_W-1:0] corr_temp, // Offset-corrected readings
    output reg [3*8-1:0] fan_duty, // Fan drive duty per fan
    output reg full_speed, // Critical override active
    output wire overtemp_pin_out, // Overtemp pin output value (low when asserted)
    output wire overtemp_pin_oe, // Overtemp pin output enable
    output wire overtemp_pin_seen, // Synchronised overtemp pin level
    output wire tree_test_enable, // Logic-tree test mode
    output wire irq // Level interrupt
);

    localparam TW = TEMP_W + 2; // Comparison width with headroom

    reg [7:0] start_reg [0:2];
    reg [7:0] crit_reg [0:2];
    reg [7:0] offs_reg [0:2];
    reg [7:0] r1lc_hyst_reg;
    reg [7:0] r2_hyst_reg;
    reg [7:0] test_en_reg;
    reg [7:0] ctrl_reg;
    reg [`TLO_ST_WIDTH-1:0] status_reg;
    reg [`TLO_ST_WIDTH-1:0] mask_reg;
    reg [1:0] fan_state_reg [0:2];
    reg [2:0] crit_hold_reg;
    reg [2:0] pin_trip_reg;
    reg [1:0] pin_sync_reg;
    reg [`TLO_ST_WIDTH-1:0] events;
    integer j; // Loop index of the event decode only
    integer k; // Loop index of the duty process only

    // Widen a whole-degree threshold to the quarter-degree scale
    function [TW-1:0] deg_to_q;
        input [8:0] deg;
        begin
            deg_to_q = {{(TW-9-`TLO_FRAC_BITS){deg[8]}}, deg, {`TLO_FRAC_BITS{1'b0}}};
        end
    endfunction

    // Hysteresis nibble for one channel
    function [3:0] hyst_of;
        input [1:0] ch;
        input [7:0] r1lc;
        input [7:0] r2;
        begin
            case (ch)
                `TLO_CH_R1: hyst_of = r1lc[`TLO_HYST_HI_MSB:`TLO_HYST_HI_LSB];
                `TLO_CH_LC: hyst_of = r1lc[`TLO_HYST_LO_MSB:`TLO_HYST_LO_LSB];
                default: hyst_of = r2[`TLO_HYST_HI_MSB:`TLO_HYST_HI_LSB];
            endcase
        end
    endfunction

    wire wr_ok = reg_wr & ~lock;
    wire pin_as_output = ctrl_reg[`TLO_CTRL_PIN_OUT_BIT];

    // Register writes; status bits are write-one-to-clear, a new event wins
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_reg[0] <= `TLO_RST_START;
            start_reg[1] <= `TLO_RST_START;
            start_reg[2] <= `TLO_RST_START;
            crit_reg[0] <= `TLO_RST_CRIT;
            crit_reg[1] <= `TLO_RST_CRIT;
            crit_reg[2] <= `TLO_RST_CRIT;
            offs_reg[0] <= `TLO_RST_ZERO;
            offs_reg[1] <= `TLO_RST_ZERO;
            offs_reg[2] <= `TLO_RST_ZERO;
            r1lc_hyst_reg <= `TLO_RST_R1LC_HYST;
            r2_hyst_reg <= `TLO_RST_R2_HYST;
            test_en_reg <= `TLO_RST_ZERO;
            ctrl_reg <= `TLO_RST_ZERO;
            mask_reg <= {`TLO_ST_WIDTH{1'b0}};
            status_reg <= {`TLO_ST_WIDTH{1'b0}};
        end else begin
            if (wr_ok) begin
                case (reg_addr)
                    `TLO_ADDR_R1_START: start_reg[0] <= reg_wdata;
                    `TLO_ADDR_LC_START: start_reg[1] <= reg_wdata;
                    `TLO_ADDR_R2_START: start_reg[2] <= reg_wdata;
                    `TLO_ADDR_R1_CRIT: crit_reg[0] <= reg_wdata;
                    `TLO_ADDR_LC_CRIT: crit_reg[1] <= reg_wdata;
                    `TLO_ADDR_R2_CRIT: crit_reg[2] <= reg_wdata;
                    `TLO_ADDR_R1LC_HYST: r1lc_hyst_reg <= reg_wdata;
                    `TLO_ADDR_R2_HYST: r2_hyst_reg <= reg_wdata;
                    `TLO_ADDR_TEST_EN: test_en_reg <= reg_wdata;
                    `TLO_ADDR_R1_OFFS: offs_reg[0] <= reg_wdata;
                    `TLO_ADDR_LC_OFFS: offs_reg[1] <= reg_wdata;
                    `TLO_ADDR_R2_OFFS: offs_reg[2] <= reg_wdata;
                    `TLO_ADDR_CTRL: ctrl_reg <= reg_wdata;
                    `TLO_ADDR_MASK: mask_reg <= reg_wdata[`TLO_ST_WIDTH-1:0];
                    default: ;
                endcase
            end
            // Clearing stays allowed under lock so a locked system can still service irq
            if (reg_wr && reg_addr == `TLO_ADDR_STATUS)
                status_reg <= (status_reg & ~reg_wdata[`TLO_ST_WIDTH-1:0]) | events;
            else
                status_reg <= status_reg | events;
        end
    end

    // Read port, one cycle latency; unmapped addresses read zero
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TLO_ADDR_R1_START: reg_rdata <= start_reg[0];
                `TLO_ADDR_LC_START: reg_rdata <= start_reg[1];
                `TLO_ADDR_R2_START: reg_rdata <= start_reg[2];
                `TLO_ADDR_R1_CRIT: reg_rdata <= crit_reg[0];
                `TLO_ADDR_LC_CRIT: reg_rdata <= crit_reg[1];
                `TLO_ADDR_R2_CRIT: reg_rdata <= crit_reg[2];
                `TLO_ADDR_R1LC_HYST: reg_rdata <= r1lc_hyst_reg;
                `TLO_ADDR_R2_HYST: reg_rdata <= r2_hyst_reg;
                `TLO_ADDR_TEST_EN: reg_rdata <= test_en_reg;
                `TLO_ADDR_R1_OFFS: reg_rdata <= offs_reg[0];
                `TLO_ADDR_LC_OFFS: reg_rdata <= offs_reg[1];
                `TLO_ADDR_R2_OFFS: reg_rdata <= offs_reg[2];
                `TLO_ADDR_CTRL: reg_rdata <= ctrl_reg;
                `TLO_ADDR_STATUS: reg_rdata <= {{(8-`TLO_ST_WIDTH){1'b0}}, status_reg};
                `TLO_ADDR_MASK: reg_rdata <= {{(8-`TLO_ST_WIDTH){1'b0}}, mask_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    assign tree_test_enable = test_en_reg[`TLO_TEST_EN_BIT];
    assign irq = |(status_reg & mask_reg);

    // Pin input synchroniser; only the second stage is read
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            pin_sync_reg <= 2'b11;
        else
            pin_sync_reg <= {pin_sync_reg[0], overtemp_pin_in};
    end
    assign overtemp_pin_seen = pin_sync_reg[1];

    // Per-channel corrected reading and threshold compares
    genvar g;
    wire [TEMP_W-1:0] corr_w [0:2];
    wire [TW-1:0] t_q [0:2];
    wire [TW-1:0] start_q [0:2];
    wire [TW-1:0] start_lo_q [0:2];
    wire [TW-1:0] crit_q [0:2];
    wire [TW-1:0] crit_lo_q [0:2];
    wire [2:0] crit_en;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ch
            wire signed [TW-1:0] raw_s;
            wire signed [TW-1:0] off_s;
            wire [3:0] hy;
            // Channel number as a sized constant; a genvar cannot be part-selected
            localparam [1:0] CH = g;
            assign raw_s = {{(TW-TEMP_W){raw_temp[g*TEMP_W+TEMP_W-1]}},
                            raw_temp[g*TEMP_W +: TEMP_W]};
            assign off_s = {{(TW-8){offs_reg[g][7]}}, offs_reg[g]};
            // Offset step equals one reading quarter step
            assign t_q[g] = raw_s + off_s;
            assign corr_w[g] = t_q[g][TEMP_W-1:0];
            assign hy = hyst_of(CH, r1lc_hyst_reg, r2_hyst_reg);
            assign start_q[g] = deg_to_q({1'b0, start_reg[g]});
            assign start_lo_q[g] = deg_to_q({1'b0, start_reg[g]} - {5'h00, hy});
            assign crit_q[g] = deg_to_q({1'b0, crit_reg[g]});
            assign crit_lo_q[g] = deg_to_q({1'b0, crit_reg[g]} - {5'h00, hy});
            assign crit_en[g] = (crit_reg[g] != `TLO_CRIT_DISABLE);
        end
    endgenerate

    // Signed greater-than helper on the quarter-degree scale
    function gt_s;
        input [TW-1:0] a;
        input [TW-1:0] b;
        begin
            gt_s = ($signed(a) > $signed(b));
        end
    endfunction

    // Fan hysteresis state, critical hold and pin trip, updated on each new reading
    integer i;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < 3; i = i + 1)
                fan_state_reg[i] <= `TLO_FAN_OFF;
            crit_hold_reg <= 3'b000;
            pin_trip_reg <= 3'b000;
            corr_temp <= {3*TEMP_W{1'b0}};
        end else if (temp_valid) begin
            for (i = 0; i < 3; i = i + 1) begin
                corr_temp[i*TEMP_W +: TEMP_W] <= corr_w[i];
                case (fan_state_reg[i])
                    `TLO_FAN_OFF:
                        if (gt_s(t_q[i], start_q[i]))
                            fan_state_reg[i] <= `TLO_FAN_RUN;
                    `TLO_FAN_RUN:
                        if (!gt_s(t_q[i], start_q[i]))
                            fan_state_reg[i] <= `TLO_FAN_FLOOR;
                    `TLO_FAN_FLOOR:
                        if (gt_s(t_q[i], start_q[i]))
                            fan_state_reg[i] <= `TLO_FAN_RUN;
                        else if (!gt_s(t_q[i], start_lo_q[i]))
                            fan_state_reg[i] <= `TLO_FAN_OFF;
                    default: fan_state_reg[i] <= `TLO_FAN_OFF;
                endcase
                if (!crit_en[i])
                    crit_hold_reg[i] <= 1'b0;
                else if (gt_s(t_q[i], crit_q[i]))
                    crit_hold_reg[i] <= 1'b1;
                else if (gt_s(crit_lo_q[i], t_q[i]))
                    crit_hold_reg[i] <= 1'b0;
                pin_trip_reg[i] <= crit_en[i] &&
                    gt_s(t_q[i], crit_q[i] + `TLO_PIN_MARGIN);
            end
        end
    end

    // Rising edges of critical hold and fan start raise sticky events
    always @* begin
        events = {`TLO_ST_WIDTH{1'b0}};
        for (j = 0; j < 3; j = j + 1) begin
            if (temp_valid && crit_en[j] && !crit_hold_reg[j] && gt_s(t_q[j], crit_q[j]))
                events[`TLO_ST_CRIT_LSB + j] = 1'b1;
            if (temp_valid && fan_state_reg[j] == `TLO_FAN_OFF && gt_s(t_q[j], start_q[j]))
                events[`TLO_ST_START_LSB + j] = 1'b1;
        end
    end

    // Fan output duty: override first, then ramp, floor or off
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fan_duty <= {3*8{1'b0}};
            full_speed <= 1'b0;
        end else begin
            full_speed <= |crit_hold_reg;
            for (k = 0; k < 3; k = k + 1) begin
                if (|crit_hold_reg)
                    fan_duty[k*8 +: 8] <= `TLO_DUTY_FULL;
                else if (fan_state_reg[k] == `TLO_FAN_RUN)
                    fan_duty[k*8 +: 8] <= ramp_duty[k*8 +: 8];
                else if (fan_state_reg[k] == `TLO_FAN_FLOOR)
                    fan_duty[k*8 +: 8] <= floor_duty[k*8 +: 8];
                else
                    fan_duty[k*8 +: 8] <= 8'h00;
            end
        end
    end

    // Open-drain style: drive low only while tripped and configured as output
    assign overtemp_pin_oe = pin_as_output & (|pin_trip_reg);
    assign overtemp_pin_out = 1'b0;

endmodule

// ---- verification/tlo_regs_sva.sv ----
// Port-level assertions for the thermal limit register block
`timescale 1ns/1ps
module tlo_regs_sva (
    input wire clk, // Core clock
    input wire rstn, // Reset, active low
    input wire [7:0] reg_addr, // Address
    input wire [7:0] reg_wdata, // Write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire [7:0] reg_rdata, // Read data
    input wire lock, // Global lock
    input wire temp_valid, // New readings
    input wire [23:0] fan_duty, // Fan duty
    input wire full_speed, // Critical override
    input wire overtemp_pin_out, // Pin value
    input wire overtemp_pin_oe, // Pin enable
    input wire tree_test_enable, // Test mode
    input wire irq // Interrupt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Override forces every fan to full scale
    chk_full_duty: assert property (full_speed |-> fan_duty == 24'hFFFFFF)
        else $error("fan duty not full during override");
    // Override only moves two edges after a new reading, since the hold sits at temp_valid
    chk_override_rise: assert property ($rose(full_speed) |-> $past(temp_valid, 2))
        else $error("override rose without a reading");
    chk_override_fall: assert property ($fell(full_speed) |-> $past(temp_valid, 2))
        else $error("override dropped without a reading");
    // Locked writes leave test mode alone
    chk_lock_hold: assert property ((reg_wr && lock && reg_addr == 8'h6F)
        |=> $stable(tree_test_enable))
        else $error("locked write changed test mode");
    chk_test_mode: assert property ((reg_wr && !lock && reg_addr == 8'h6F)
        |=> tree_test_enable == $past(reg_wdata[0]))
        else $error("test mode does not follow bit 0");
    // Pin is only ever pulled low
    chk_pin_low: assert property (overtemp_pin_oe |-> overtemp_pin_out == 1'b0)
        else $error("pin driven high");
    // Read data moves only on a read
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    // Interrupt needs an event or a register write behind it
    chk_irq_cause: assert property ($rose(irq) |-> ($past(temp_valid) || $past(reg_wr)))
        else $error("interrupt rose without cause");
endmodule

bind tlo_thermal_limit_offset_regs tlo_regs_sva u_sva (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lock(lock), .temp_valid(temp_valid), .fan_duty(fan_duty),
    .full_speed(full_speed), .overtemp_pin_out(overtemp_pin_out),
    .overtemp_pin_oe(overtemp_pin_oe), .tree_test_enable(tree_test_enable), .irq(irq));

// ---- verification/tlo_thermal_limit_offset_regs_tb.sv ----
// Self-checking bench for the thermal limit register block
`timescale 1ns/1ps
module tlo_thermal_limit_offset_regs_tb;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg lock = 1'b0;
    reg [29:0] raw_temp = 30'h0;
    reg temp_valid = 1'b0;
    reg [23:0] ramp_duty = 24'h909090;
    reg [23:0] floor_duty = 24'h404040;
    reg overtemp_pin_in = 1'b1;
    wire [7:0] reg_rdata;
    wire [29:0] corr_temp;
    wire [23:0] fan_duty;
    wire full_speed, overtemp_pin_out, overtemp_pin_oe, overtemp_pin_seen, tree_test_enable, irq;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer i;
    reg [15:0] lfsr = 16'hBC78;
    reg [7:0] d;
    reg [7:0] v;
    reg [29:0] rt;
    reg [7:0] shadow [0:11];

    tlo_thermal_limit_offset_regs #(.TEMP_W(10)) DUT (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .lock(lock), .raw_temp(raw_temp), .temp_valid(temp_valid),
        .ramp_duty(ramp_duty), .floor_duty(floor_duty), .overtemp_pin_in(overtemp_pin_in),
        .corr_temp(corr_temp), .fan_duty(fan_duty), .full_speed(full_speed),
        .overtemp_pin_out(overtemp_pin_out), .overtemp_pin_oe(overtemp_pin_oe),
        .overtemp_pin_seen(overtemp_pin_seen), .tree_test_enable(tree_test_enable), .irq(irq));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    function [15:0] lfsr_next(input [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [7:0] rst_val(input integer n);
        rst_val = n < 3 ? 8'h5A : n < 6 ? 8'h64 : n == 6 ? 8'h44 : n == 7 ? 8'h40 : 8'h00;
    endfunction
    // Reading plus sign-extended quarter-degree offset, wrapping like the hardware
    function [9:0] exp_corr(input [9:0] raw, input [7:0] off);
        exp_corr = raw + {{2{off[7]}}, off};
    endfunction

    task check(input string name, input [31:0] exp, input [31:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %0s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task wr(input [7:0] a, input [7:0] dat);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Data is taken one cycle after the read strobe; it then holds until the next read
    task rchk(input [7:0] a, input [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        check("register", e, v);
    endtask
    // One reading; duty settles one edge after the sample edge
    task temps(input [9:0] t0, input [9:0] t1, input [9:0] t2);
        @(posedge clk);
        raw_temp <= {t2, t1, t0};
        temp_valid <= 1'b1;
        @(posedge clk);
        temp_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task complete_run;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog at 20000 cycles, far beyond the two hundred or so cycles the tests need
    initial begin
        #(25 * 20000);
        error_cnt = error_cnt + 1;
        complete_run;
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            shadow[i] = rst_val(i);
            rchk(8'h67 + i[7:0], shadow[i]);
        end
        // Small signed offsets, negative readings too, kept clear of every limit
        for (i = 0; i < 3; i = i + 1) begin
            lfsr = lfsr_next(lfsr);
            wr(8'h70 + i[7:0], {lfsr[7], lfsr[7], lfsr[5:0]});
            shadow[9 + i] = {lfsr[7], lfsr[7], lfsr[5:0]};
        end
        lfsr = lfsr_next(lfsr);
        rt = {2'b11, lfsr[11:4], 2'b00, lfsr[15:8], 2'b00, lfsr[7:0]};
        temps(rt[9:0], rt[19:10], rt[29:20]);
        for (i = 0; i < 3; i = i + 1)
            check("corr_temp", exp_corr(rt[10*i +: 10], shadow[9 + i]), corr_temp[10*i +: 10]);
        for (i = 0; i < 3; i = i + 1)
            wr(8'h70 + i[7:0], 8'h00);
        wr(8'hE1, 8'h3F);
        // Remote 1 gets six degrees, local and remote 2 keep four
        wr(8'h6D, 8'h64);
        temps(10'h16C, 10'h16C, 10'h16C);
        check("fan_run", 24'h909090, fan_duty);
        temps(10'h160, 10'h160, 10'h160);
        check("fan_floor", 24'h404040, fan_duty);
        temps(10'h158, 10'h158, 10'h158);
        check("fan_nibble", 24'h000040, fan_duty);
        // Critical entry at a quarter degree over, pin one quarter later
        wr(8'hE0, 8'h01);
        temps(10'h191, 10'h000, 10'h000);
        check("full_speed", 1, full_speed);
        check("fan_full", 24'hFFFFFF, fan_duty);
        check("pin_oe", 0, overtemp_pin_oe);
        temps(10'h192, 10'h000, 10'h000);
        check("pin_oe", 1, overtemp_pin_oe);
        wr(8'hE0, 8'h00);
        check("pin_oe", 0, overtemp_pin_oe);
        wr(8'hE0, 8'h01);
        check("pin_oe", 1, overtemp_pin_oe);
        temps(10'h17C, 10'h000, 10'h000);
        check("full_speed", 1, full_speed);
        temps(10'h174, 10'h000, 10'h000);
        check("full_speed", 0, full_speed);
        // Sticky events, mask and write-one clear
        rchk(8'hE1, 8'h39);
        check("irq", 0, irq);
        wr(8'hE2, 8'h01);
        check("irq", 1, irq);
        wr(8'hE1, 8'h01);
        check("irq", 0, irq);
        rchk(8'hE1, 8'h38);
        rchk(8'hE3, 8'h00);
        // Random contents; reserved test bits and low hysteresis are never written
        for (i = 0; i < 12; i = i + 1) begin
            lfsr = lfsr_next(lfsr);
            d = lfsr[7:0];
            if (i == 8) d = d & 8'h01;
            if (i == 6 || i == 7) d = d | 8'h44;
            shadow[i] = d;
            wr(8'h67 + i[7:0], d);
        end
        for (i = 0; i < 12; i = i + 1)
            rchk(8'h67 + i[7:0], shadow[i]);
        @(posedge clk) lock <= 1'b1;
        for (i = 0; i < 12; i = i + 1)
            wr(8'h67 + i[7:0], ~shadow[i] & ((i == 8) ? 8'h01 : 8'hFF));
        for (i = 0; i < 12; i = i + 1)
            rchk(8'h67 + i[7:0], shadow[i]);
        check("test_mode", shadow[8][0], tree_test_enable);
        @(posedge clk) lock <= 1'b0;
        wr(8'h6F, 8'h01);
        check("test_mode", 1, tree_test_enable);
        wr(8'h6F, 8'h00);
        check("test_mode", 0, tree_test_enable);
        // Pin level seen through the two-flop synchroniser
        @(posedge clk) overtemp_pin_in <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("pin_seen", 0, overtemp_pin_seen);
        complete_run;
    end
endmodule
